/* File: src/cai_top.sv */
`timescale 1ns/10ps
// How it works
// - flag set when counter wraps 0xFFFF
// - intermediate flag on carry out of bit 7-10
// - one event flag per channel
// - flags set regardless of their enables
// - each flag gated by its own enable
// - one request, needs global and array enable
// - each channel holds independent mode
// - mode from channel and shared config registers
// - rising-edge capture decode
// - falling-edge capture decode
// - any-edge capture decode, bits 7:6 ignored
// - software timer and high-speed output decode
// - comparator off stops matches and toggling
// - length select picks intermediate carry bit
module cai_top
  import cai_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          sys_rst_i,
  // apb slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [7:0]                    paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  // channel pins
  input  wire logic [cai_pkg::NUM_CH-1:0]    channel_pin_i,
  output logic      [cai_pkg::NUM_CH-1:0]    channel_pin_o,
  output logic      [cai_pkg::NUM_CH-1:0]    channel_pin_oe_o,
  // interrupt
  output logic                               irq_o
);

  logic [3:0]        ctrl_r;
  logic [7:0]        pwm_config_reg_r;
  logic [7:0]        flags_r;
  logic [7:0]        flags_nxt;
  logic [7:0]        mask_r;
  logic [15:0]       counter_r;
  logic [15:0]       counter_nxt;
  logic [7:0]        channel_mode_reg_r [NUM_CH];
  logic [15:0]       value      [NUM_CH];
  logic [NUM_CH-1:0] ch_event;
  logic [NUM_CH-1:0] ch_pin;
  logic [NUM_CH-1:0] ch_pin_oe;
  logic [NUM_CH-1:0] pin_sync;
  logic [NUM_CH-1:0] value_we;
  logic [7:0]        irq_en;
  logic [7:0]        set_ev;
  logic              counter_wrap;
  logic              intermediate_wrap;
  logic              setup;
  logic              wr_go;
  logic              addr_hit;
  logic [31:0]       rdata;
  logic [1:0]        pwm_length_select;
  logic [NUM_CH-1:0] mode_we;
  logic              wr_ctrl;
  logic              wr_pwm;
  logic              wr_flags;
  logic              wr_mask;
  logic              wr_cnt;
  logic              cnt_step;
  logic              inter_carry;
  logic              irq_req;

  // apb access
  // one wait-free access phase: pready is raised by the setup cycle
  assign setup = psel_i && !penable_i;
  assign wr_go = psel_i && penable_i && pready_o && pwrite_i;

  // one write strobe per register, decoded once
  always_comb begin
    wr_ctrl  = wr_go && (paddr_i == ADDR_CTRL);
    wr_pwm   = wr_go && (paddr_i == ADDR_PWM_CFG);
    wr_flags = wr_go && (paddr_i == ADDR_FLAGS);
    wr_mask  = wr_go && (paddr_i == ADDR_MASK);
    wr_cnt   = wr_go && (paddr_i == ADDR_COUNTER);
  end

  // read mux; unmapped offsets read zero and raise the error
  always_comb begin
    rdata    = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr_i)
      ADDR_CTRL:    rdata = {28'h000_0000, ctrl_r};
      ADDR_PWM_CFG: rdata = {24'h00_0000, pwm_config_reg_r};
      ADDR_FLAGS:   rdata = {24'h00_0000, flags_r};
      ADDR_MASK:    rdata = {24'h00_0000, mask_r};
      ADDR_COUNTER: rdata = {16'h0000, counter_r};
      default: begin
        addr_hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
          if (paddr_i == ADDR_MODE0 + 8'(i) * ADDR_STRIDE) begin
            rdata    = {24'h00_0000, channel_mode_reg_r[i]};
            addr_hit = 1'b1;
          end
          if (paddr_i == ADDR_VALUE0 + 8'(i) * ADDR_STRIDE) begin
            rdata    = {16'h0000, value[i]};
            addr_hit = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && !addr_hit;
    end
  end

  // read data stands only in the read's access cycle, zero otherwise
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      prdata_o <= rdata;
    end else begin
      prdata_o <= 32'h0000_0000;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata_i[3:0];
    end
  end

  // the length field only picks the intermediate carry bit; no channel reads it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pwm_config_reg_r <= PWM_CFG_RESET;
    end else if (wr_pwm) begin
      pwm_config_reg_r <= pwdata_i[7:0];
    end
  end

  // mask resets open, so the documented enables alone decide
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mask_r <= MASK_RESET;
    end else if (wr_mask) begin
      mask_r <= pwdata_i[7:0];
    end
  end

  // each channel has a mode register of its own
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_mode_reg_r[i] <= MODE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (mode_we[i]) begin
          channel_mode_reg_r[i] <= pwdata_i[7:0];
        end
      end
    end
  end

  // per-channel strobes for mode and capture/compare value
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      mode_we[i]  = wr_go && (paddr_i == ADDR_MODE0 + 8'(i) * ADDR_STRIDE);
      value_we[i] = wr_go && (paddr_i == ADDR_VALUE0 + 8'(i) * ADDR_STRIDE);
    end
  end

  // shared counter
  assign pwm_length_select = pwm_config_reg_r[PWM_LEN_LSB +: 2];
  // a load in the same cycle replaces the step, so it reports no wrap
  assign cnt_step          = ctrl_r[CTRL_RUN_BIT] && !wr_cnt;
  assign counter_wrap      = cnt_step && (counter_r == COUNTER_FULL);

  // carry out of the selected low bit position
  always_comb begin
    case (pwm_length_select)
      2'h0:    inter_carry = &counter_r[7:0];
      2'h1:    inter_carry = &counter_r[8:0];
      2'h2:    inter_carry = &counter_r[9:0];
      2'h3:    inter_carry = &counter_r[10:0];
      default: inter_carry = 1'b0;
    endcase
  end

  assign intermediate_wrap = cnt_step && inter_carry;

  // software load wins over counting
  always_comb begin
    counter_nxt = counter_r;
    if (wr_cnt) begin
      counter_nxt = pwdata_i[15:0];
    end else if (cnt_step) begin
      counter_nxt = counter_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      counter_r <= COUNTER_RESET;
    end else begin
      counter_r <= counter_nxt;
    end
  end

  // channels
  // pins are async, so they pass two flops before the edge detectors
  cai_sync2 #(
    .WIDTH (NUM_CH)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (channel_pin_i),
    .sync_o    (pin_sync)
  );

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    cai_channel u_ch (
      .sys_clk_i     (sys_clk_i),
      .sys_rst_i     (sys_rst_i),
      .mode_i        (channel_mode_reg_r[g]),
      .pwm_sel_i     (pwm_config_reg_r[PWM_NOT_CAP_BIT]),
      .counter_i     (counter_r),
      .pin_i         (pin_sync[g]),
      .value_we_i    (value_we[g]),
      .value_wdata_i (pwdata_i[15:0]),
      .value_o       (value[g]),
      .event_o       (ch_event[g]),
      .pin_o         (ch_pin[g]),
      .pin_oe_o      (ch_pin_oe[g])
    );
  end

  assign channel_pin_o    = ch_pin;
  assign channel_pin_oe_o = ch_pin_oe;

  // event flags
  always_comb begin
    set_ev                = 8'h00;
    set_ev[FLAG_WRAP_BIT] = counter_wrap;
    set_ev[FLAG_INT_BIT]  = intermediate_wrap;
    set_ev[FLAG_CH_LSB +: NUM_CH] = ch_event;
  end

  // write-one-to-clear; a new event in the same cycle wins over the clear
  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = flags_r & ~pwdata_i[7:0];
    end
    flags_nxt = flags_nxt | set_ev;
  end

  // flags never clear themselves; only software drops them
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // interrupt: documented enables, one per flag
  always_comb begin
    irq_en                = 8'h00;
    irq_en[FLAG_WRAP_BIT] = ctrl_r[CTRL_WRAP_EN_BIT];
    irq_en[FLAG_INT_BIT]  = pwm_config_reg_r[PWM_INT_EN_BIT];
    for (int i = 0; i < NUM_CH; i++) begin
      irq_en[FLAG_CH_LSB + i] = channel_mode_reg_r[i][MODE_IRQ_EN_BIT];
    end
  end

  // enabled flags, before the array and global gates
  assign irq_req = |(flags_r & irq_en & mask_r);

  // registered, so the request pin never glitches
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ctrl_r[CTRL_GLOBAL_EN] && ctrl_r[CTRL_ARRAY_EN] && irq_req;
    end
  end

endmodule

/* File: src/cai_pkg.sv */
package cai_pkg;

  localparam int unsigned NUM_CH = 6;
  localparam int unsigned CNT_W  = 16;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PWM_CFG = 8'h04;
  localparam logic [7:0] ADDR_FLAGS   = 8'h08;
  localparam logic [7:0] ADDR_MASK    = 8'h0C;
  localparam logic [7:0] ADDR_COUNTER = 8'h10;
  localparam logic [7:0] ADDR_MODE0   = 8'h20;
  localparam logic [7:0] ADDR_VALUE0  = 8'h40;
  localparam logic [7:0] ADDR_STRIDE  = 8'h04;

  // control register fields
  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam int unsigned CTRL_ARRAY_EN    = 1;
  localparam int unsigned CTRL_GLOBAL_EN   = 2;
  localparam int unsigned CTRL_WRAP_EN_BIT = 3;
  localparam logic [3:0]  CTRL_RESET       = 4'h0;

  // shared pwm configuration fields
  localparam int unsigned PWM_NOT_CAP_BIT = 7;
  localparam int unsigned PWM_INT_EN_BIT  = 5;
  localparam int unsigned PWM_LEN_LSB     = 0;
  localparam logic [7:0]  PWM_CFG_RESET   = 8'h00;

  // flag / mask layout: bit0 counter wrap, bit1 intermediate wrap, bits 7:2 channels
  localparam int unsigned FLAG_WRAP_BIT = 0;
  localparam int unsigned FLAG_INT_BIT  = 1;
  localparam int unsigned FLAG_CH_LSB   = 2;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'hFF;

  // channel mode register fields
  localparam int unsigned MODE_CMP_EN_BIT = 6;
  localparam int unsigned MODE_RISE_BIT   = 5;
  localparam int unsigned MODE_FALL_BIT   = 4;
  localparam int unsigned MODE_MATCH_BIT  = 3;
  localparam int unsigned MODE_TOGGLE_BIT = 2;
  localparam int unsigned MODE_PWM_BIT    = 1;
  localparam int unsigned MODE_IRQ_EN_BIT = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [15:0] VALUE_RESET     = 16'h0000;
  localparam logic [15:0] COUNTER_RESET   = 16'h0000;
  localparam logic [15:0] COUNTER_FULL    = 16'hFFFF;

  typedef enum logic [2:0] {
    CAI_MODE_IDLE,
    CAI_MODE_CAP_RISE,
    CAI_MODE_CAP_FALL,
    CAI_MODE_CAP_ANY,
    CAI_MODE_SW_TIMER,
    CAI_MODE_HS_OUT
  } cai_mode_type;

endpackage

/* File: src/cai_sync2.sv */
`timescale 1ns/10ps
module cai_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // async in, synced out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

/* File: src/cai_channel.sv */
`timescale 1ns/10ps
module cai_channel
  import cai_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // configuration
  input  wire logic [7:0]  mode_i,
  input  wire logic        pwm_sel_i,
  // counter and pin
  input  wire logic [15:0] counter_i,
  input  wire logic        pin_i,
  // software write of the capture/compare value
  input  wire logic        value_we_i,
  input  wire logic [15:0] value_wdata_i,
  // results
  output logic [15:0]      value_o,
  output logic             event_o,
  output logic             pin_o,
  output logic             pin_oe_o
);

  cai_mode_type mode;
  logic         pin_d_r;
  logic         rise;
  logic         fall;
  logic         capture;
  logic         match;

  always_comb begin
    mode = CAI_MODE_IDLE;
    if (!pwm_sel_i && !mode_i[MODE_PWM_BIT]) begin
      case (mode_i[MODE_MATCH_BIT:MODE_TOGGLE_BIT])
        2'h0: begin
          if (mode_i[MODE_RISE_BIT] && mode_i[MODE_FALL_BIT]) begin
            mode = CAI_MODE_CAP_ANY;
          end else if (mode_i[MODE_RISE_BIT]) begin
            mode = CAI_MODE_CAP_RISE;
          end else if (mode_i[MODE_FALL_BIT]) begin
            mode = CAI_MODE_CAP_FALL;
          end
        end
        2'h2: begin
          if (mode_i[MODE_RISE_BIT:MODE_FALL_BIT] == 2'h0) begin
            mode = CAI_MODE_SW_TIMER;
          end
        end
        2'h3: begin
          if (mode_i[MODE_RISE_BIT:MODE_FALL_BIT] == 2'h0) begin
            mode = CAI_MODE_HS_OUT;
          end
        end
        default: mode = CAI_MODE_IDLE;
      endcase
    end
  end

  assign rise = pin_i && !pin_d_r;
  assign fall = !pin_i && pin_d_r;

  always_comb begin
    case (mode)
      CAI_MODE_CAP_RISE: capture = rise;
      CAI_MODE_CAP_FALL: capture = fall;
      CAI_MODE_CAP_ANY:  capture = rise || fall;
      default:           capture = 1'b0;
    endcase
  end

  // comparator off stops matches and toggling
  assign match = mode_i[MODE_CMP_EN_BIT] && (counter_i == value_o) &&
                 (mode == CAI_MODE_SW_TIMER || mode == CAI_MODE_HS_OUT);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= pin_i;
    end
  end

  // a capture beats a software write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      value_o <= VALUE_RESET;
    end else if (capture) begin
      value_o <= counter_i;
    end else if (value_we_i) begin
      value_o <= value_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= capture || match;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_oe_o <= (mode == CAI_MODE_HS_OUT);
      if (mode == CAI_MODE_HS_OUT && match) begin
        pin_o <= !pin_o;
      end
    end
  end

endmodule

/* File: sim/cai_top_chk.sv */
`timescale 1ns/10ps
module cai_top_chk
  import cai_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  // apb
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [31:0]       prdata_o,
  input  wire logic              pready_o,
  input  wire logic              pslverr_o,
  // pins and request
  input  wire logic [NUM_CH-1:0] channel_pin_i,
  input  wire logic [NUM_CH-1:0] channel_pin_o,
  input  wire logic [NUM_CH-1:0] channel_pin_oe_o,
  input  wire logic              irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic wr_done;
  logic mapped;
  assign wr_done = pready_o && pwrite_i;
  assign mapped  = paddr_i[1:0] == 2'b00 && (paddr_i <= ADDR_COUNTER
                   || (paddr_i >= ADDR_MODE0 && paddr_i <= 8'h34)
                   || (paddr_i >= ADDR_VALUE0 && paddr_i <= 8'h54));

  chk_setup_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  chk_ready_access: assert property (pready_o |-> psel_i && penable_i
    && $past(psel_i && !penable_i)) else $error("ready outside access");
  chk_error_map: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("error flag disagrees with map");
  chk_error_access: assert property (pslverr_o |-> pready_o)
    else $error("error outside access");
  chk_idle_data: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero when idle");
  chk_irq_gate:
    assert property (wr_done && paddr_i == ADDR_CTRL
      && !(pwdata_i[CTRL_ARRAY_EN] && pwdata_i[CTRL_GLOBAL_EN]) |=> ##1 !irq_o [*2])
    else $error("request while array or global enable off");
  chk_mask_zero:
    assert property (wr_done && paddr_i == ADDR_MASK && pwdata_i[7:0] == 8'h00
      |=> ##1 !irq_o) else $error("request with all flags masked");
  chk_sticky_irq:
    assert property ($fell(irq_o) |-> $past(wr_done, 2))
    else $error("request dropped without a write");
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_oe
    chk_oe_mode:
      assert property (wr_done && paddr_i == ADDR_MODE0 + 8'(4 * ch)
        && pwdata_i[5:1] != 5'b00110 |=> ##1 !channel_pin_oe_o[ch])
      else $error("pin driven outside high speed output");
  end

  cov_irq: cover property ($rose(irq_o));
  cov_err: cover property (pslverr_o);
  cov_hso: cover property ($rose(channel_pin_oe_o[4]));
endmodule

bind cai_top cai_top_chk cai_top_chk_i (
  .sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .channel_pin_i, .channel_pin_o,
  .channel_pin_oe_o, .irq_o
);

/* File: sim/cai_partner.sv */
`timescale 1ns/10ps
module cai_partner
  import cai_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  // bench pin request and device request
  input  wire logic [NUM_CH-1:0] pin_cmd_i,
  input  wire logic              irq_i,
  // pin levels and requests taken
  output logic      [NUM_CH-1:0] pin_o,
  output logic      [7:0]        irq_seen_o
);
  logic irq_d_r;
  // levels move only on an edge, so every level lasts whole cycles
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_o <= '0;
    end else begin
      pin_o <= pin_cmd_i;
    end
  end
  // cpu side counts each new request it would vector to
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_d_r    <= 1'b0;
      irq_seen_o <= 8'h00;
    end else begin
      irq_d_r    <= irq_i;
      irq_seen_o <= irq_seen_o + 8'(irq_i && !irq_d_r);
    end
  end
endmodule

/* File: sim/counter_array_irq_mode_select_bench.sv */
`timescale 1ns/10ps
module counter_array_irq_mode_select_bench;
  import cai_pkg::*;
  logic              sys_clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              psel_i    = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i  = 1'b0;
  logic [7:0]        paddr_i   = 8'h00;
  logic [31:0]       pwdata_i  = 32'h0;
  logic [NUM_CH-1:0] pin_cmd   = '0;
  logic [NUM_CH-1:0] pin_lvl;
  logic [31:0]       prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic [NUM_CH-1:0] pin_drv;
  logic [NUM_CH-1:0] pin_oe;
  logic              irq_o;
  logic [7:0]        irq_seen;
  logic [31:0]       rd;
  logic              err;
  int                n_fail      = 0;
  int                check_count = 0;
  logic [7:0]  ra[7] = '{ADDR_CTRL, ADDR_PWM_CFG, ADDR_FLAGS, ADDR_MASK,
                         ADDR_COUNTER, ADDR_MODE0, ADDR_VALUE0};
  logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [24:0] it[8] = '{{8'h0E, 8'h00, 8'hFF, 1'b1}, {8'h0A, 8'h00, 8'hFF, 1'b0},
                         {8'h0C, 8'h00, 8'hFF, 1'b0}, {8'h06, 8'h20, 8'hFF, 1'b1},
                         {8'h06, 8'h00, 8'hFF, 1'b0}, {8'h0E, 8'h20, 8'hFE, 1'b1},
                         {8'h0E, 8'h20, 8'h00, 1'b0}, {8'h0E, 8'h20, 8'hFF, 1'b1}};
  logic [7:0]  md[6] = '{8'h21, 8'h11, 8'hF1, 8'h49, 8'h4D, 8'h0D};

  cai_top cai_top_i (
    .sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .channel_pin_i(pin_lvl),
    .channel_pin_o(pin_drv), .channel_pin_oe_o(pin_oe), .irq_o
  );
  cai_partner cai_partner_i (
    .sys_clk_i, .sys_rst_i, .pin_cmd_i(pin_cmd), .irq_i(irq_o),
    .pin_o(pin_lvl), .irq_seen_o(irq_seen)
  );

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      close_out();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // counter frozen, loaded, then run a few cycles across one boundary
  task automatic carry(input int k, input logic [15:0] start, input logic [1:0] exp);
    wr_reg(ADDR_CTRL, 32'h0);
    wr_reg(ADDR_PWM_CFG, 32'(k));
    wr_reg(ADDR_COUNTER, 32'(start));
    wr_reg(ADDR_FLAGS, 32'hFF);
    wr_reg(ADDR_CTRL, 32'h1);
    repeat (6) @(posedge sys_clk_i);
    wr_reg(ADDR_CTRL, 32'h0);
    rd_reg(ADDR_FLAGS);
    chk("wrap flags", 32'(rd[1:0]), 32'(exp));
    chk("request", 32'(irq_o), 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      chk("reset value", rd, 32'(rv[i]));
    end
    rd_reg(8'h14);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      carry(k, (16'h0100 << k) - 16'h0002, 2'b10);
      if (k > 0) carry(k, 16'h00FE, 2'b00);
    end
    carry(0, 16'hFFFE, 2'b11);
    $display("test carry done");
    foreach (it[i]) begin
      wr_reg(ADDR_CTRL, 32'(it[i][24:17]));
      wr_reg(ADDR_PWM_CFG, 32'(it[i][16:9]));
      wr_reg(ADDR_MASK, 32'(it[i][8:1]));
      repeat (3) @(posedge sys_clk_i);
      chk("request gate", 32'(irq_o), 32'(it[i][0]));
    end
    wr_reg(ADDR_FLAGS, 32'h01);
    rd_reg(ADDR_FLAGS);
    chk("flags after clear", rd, 32'h02);
    chk("request kept", 32'(irq_o), 32'h1);
    wr_reg(ADDR_FLAGS, 32'h02);
    repeat (3) @(posedge sys_clk_i);
    chk("request gone", 32'(irq_o), 32'h0);
    $display("test request done");
    wr_reg(ADDR_PWM_CFG, 32'h0);
    wr_reg(ADDR_CTRL, 32'h06);
    wr_reg(ADDR_COUNTER, 32'h1234);
    foreach (md[i]) begin
      wr_reg(ADDR_MODE0 + 8'(4 * i), 32'(md[i]));
      wr_reg(ADDR_VALUE0 + 8'(4 * i), 32'h1240);
    end
    wr_reg(ADDR_FLAGS, 32'hFF);
    pin_cmd <= 6'h3F;
    repeat (8) @(posedge sys_clk_i);
    rd_reg(ADDR_FLAGS);
    chk("rising flags", rd, 32'h14);
    chk("channel request", 32'(irq_o), 32'h1);
    rd_reg(ADDR_VALUE0);
    chk("captured count", rd, 32'h1234);
    wr_reg(ADDR_FLAGS, 32'hFF);
    pin_cmd <= 6'h00;
    repeat (8) @(posedge sys_clk_i);
    rd_reg(ADDR_FLAGS);
    chk("falling flags", rd, 32'h18);
    $display("test capture done");
    wr_reg(ADDR_FLAGS, 32'hFF);
    wr_reg(ADDR_CTRL, 32'h07);
    repeat (30) @(posedge sys_clk_i);
    wr_reg(ADDR_CTRL, 32'h06);
    rd_reg(ADDR_FLAGS);
    chk("match flags", rd, 32'h60);
    chk("output enables", 32'(pin_oe), 32'h30);
    chk("output levels", 32'(pin_drv[5:4]), 32'h1);
    wr_reg(ADDR_PWM_CFG, 32'h80);
    wr_reg(ADDR_FLAGS, 32'hFF);
    pin_cmd <= 6'h3F;
    repeat (8) @(posedge sys_clk_i);
    rd_reg(ADDR_FLAGS);
    chk("idle channels", 32'(rd[7:2]), 32'h0);
    chk("idle enables", 32'(pin_oe), 32'h0);
    chk("requests taken", 32'(irq_seen != 8'h00), 32'h1);
    $display("test modes done");
    close_out();
  end

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_fail++;
    close_out();
  end
endmodule
